// ### rtl/disc_ctl_defines.svh
// Named constants for the disc track verify and write retry block
`ifndef DISC_CTL_DEFINES_SVH
`define DISC_CTL_DEFINES_SVH
`define TRACK_ID_W 6
`define RETRY_LIMIT 2'h3
`define WRITE_LIMIT 2'h3
`define STATUS_W 8
`define PART_W 8
`define SEL_CONTROL 0
`define SEL_CYLINDER 1
`define SEL_HEAD_DIR 2
`define SEL_DIFFERENCE 3
`define SEL_W 4
`define ZERO2 2'h0
`define ONE2 2'h1
`endif

// ### rtl/disc_ctl_pkg.sv
// Types shared by the disc track verify and write retry block
`include "disc_ctl_defines.svh"
package disc_ctl_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_WAIT_PREAMBLE = 3'b001,
        ST_COMPARE = 3'b010,
        ST_WRITE = 3'b011,
        ST_VERIFY = 3'b100,
        ST_STATUS = 3'b101
    } op_state_t;
    typedef struct packed {
        logic wrong_track;
        logic error;
        logic bad_sector;
        logic recal;
    } fault_t;
endpackage

// ### rtl/disc_track_verify_write_retry.sv
// Disc controller track verify, write retry and drive select control
// Functional notes
// - Four select lines choose file bus group
// - Select lines gated off during system reset
// - Terminate pulse clears stored partition number
// - Write command sets track read flag
// - Track identifier is six bits modulo 64
// - Mismatch retries; fourth failure sets wrong track
// - Wrong track forces recalibrate and error
// - Three verified write attempts then mark bad
// - Operation started with seek needed issues disconnect reset
// - Tunnel erase set/cleared by cylinder, sector
// - Hold switch freezes state on bad status
// - Single pulse on preamble detection
// - Write routed only to selected drive
// - System reset clears operation state
// - Status flip-flop drives ready and data
// - Controller clear from reset or status done
`timescale 1ns/1ps
`include "disc_ctl_defines.svh"
module disc_track_verify_write_retry (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic power_fail_manual_reset,
    input wire logic [`SEL_W-1:0] select_request,
    input wire logic start_read,
    input wire logic start_write,
    input wire logic seek_needed,
    input wire logic on_cylinder,
    input wire logic preamble_seen,
    input wire logic [`TRACK_ID_W-1:0] track_id_in,
    input wire logic [`TRACK_ID_W-1:0] cylinder_addr,
    input wire logic verify_ok,
    input wire logic verify_done,
    input wire logic sector_pulse,
    input wire logic [`TRACK_ID_W-1:0] erase_on_sector,
    input wire logic [`TRACK_ID_W-1:0] erase_off_sector,
    input wire logic transfer_terminate_pulse,
    input wire logic [`PART_W-1:0] partition_in,
    input wire logic partition_load,
    input wire logic hold_on_fault_switch,
    input wire logic drive_b_selected,
    input wire logic status_taken,
    output logic select_control_group,
    output logic select_cylinder_group,
    output logic select_head_direction_group,
    output logic select_difference_group,
    output logic write_a,
    output logic write_b,
    output logic tunnel_erase_ff,
    output logic track_read_ff,
    output logic write_attempt_three,
    output logic op_disconnect_reset,
    output logic preamble_detect_pulse,
    output logic status_ready,
    output logic [`STATUS_W-1:0] channel_data_lines,
    output logic [`PART_W-1:0] partition_number,
    output disc_ctl_pkg::fault_t fault
);
    import disc_ctl_pkg::*;

    // Pin synchronisers: two stages before any logic
    logic [1:0] s_pre, s_sysrst, s_hold;
    logic pre_sync, sysrst_sync, hold_sync;
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            s_pre <= `ZERO2;
            s_sysrst <= `ZERO2;
            s_hold <= `ZERO2;
        end else begin
            s_pre <= {s_pre[0], preamble_seen};
            s_sysrst <= {s_sysrst[0], power_fail_manual_reset};
            s_hold <= {s_hold[0], hold_on_fault_switch};
        end
    end
    assign pre_sync = s_pre[1];
    assign sysrst_sync = s_sysrst[1];
    assign hold_sync = s_hold[1];

    // Preamble edge to a one-cycle pulse
    pulse_gen u_pre (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .level(pre_sync),
        .pulse(preamble_detect_pulse)
    );

    op_state_t state, next_state;
    logic [1:0] retry_cnt, next_retry_cnt;
    logic [1:0] tally, next_tally;
    logic is_write, next_is_write;
    logic next_track_read;
    logic next_tunnel;
    logic next_disc_rst;
    logic [`PART_W-1:0] next_partition;
    fault_t next_fault;
    logic controller_clear;
    logic frozen;
    logic id_match;

    // Clear from system reset or finished status delivery
    assign controller_clear = sysrst_sync |
        (state == ST_STATUS && status_taken);
    // Freeze only while bad status is reported and switch is on;
    // system reset still wins so a frozen controller can be recovered
    assign frozen = hold_sync && !sysrst_sync && state == ST_STATUS &&
        (fault.error || fault.bad_sector);
    // Six-bit compare wraps naturally modulo 64
    assign id_match = track_id_in == cylinder_addr;

    // Operation sequencer next-state logic
    always_comb begin
        next_state = state;
        next_retry_cnt = retry_cnt;
        next_tally = tally;
        next_is_write = is_write;
        next_track_read = track_read_ff;
        next_fault = fault;
        next_disc_rst = 1'b0;
        next_partition = partition_number;
        if (partition_load) begin
            next_partition = partition_in;
        end
        if (transfer_terminate_pulse) begin
            next_partition = '0;
        end
        unique case (state)
            ST_IDLE: begin
                if (start_read || start_write) begin
                    next_retry_cnt = `ZERO2;
                    next_tally = `ZERO2;
                    next_is_write = start_write;
                    next_fault = '0;
                    next_track_read = start_write;
                    next_state = ST_WAIT_PREAMBLE;
                    // Seek cannot finish this cycle: release host
                    next_disc_rst = seek_needed;
                end
            end
            ST_WAIT_PREAMBLE: begin
                // First sector after the heads are on cylinder
                if (on_cylinder && preamble_detect_pulse) begin
                    next_state = ST_COMPARE;
                end
            end
            ST_COMPARE: begin
                if (id_match) begin
                    next_track_read = 1'b0;
                    next_state = is_write ? ST_WRITE : ST_STATUS;
                end else if (retry_cnt == `RETRY_LIMIT) begin
                    next_fault.wrong_track = 1'b1;
                    next_fault.recal = 1'b1;
                    next_fault.error = 1'b1;
                    next_state = ST_STATUS;
                end else begin
                    next_retry_cnt = retry_cnt + `ONE2;
                    next_state = ST_WAIT_PREAMBLE;
                end
            end
            ST_WRITE: begin
                next_tally = tally + `ONE2;
                next_state = ST_VERIFY;
            end
            ST_VERIFY: begin
                if (verify_done) begin
                    if (verify_ok) begin
                        next_state = ST_STATUS;
                    end else if (tally == `WRITE_LIMIT) begin
                        next_fault.bad_sector = 1'b1;
                        next_fault.error = 1'b1;
                        next_state = ST_STATUS;
                    end else begin
                        next_state = ST_WRITE;
                    end
                end
            end
            ST_STATUS: begin
                if (status_taken) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
        // Counters and flags are held as well while frozen
        if (controller_clear && !frozen) begin
            next_state = ST_IDLE;
            next_track_read = 1'b0;
            next_retry_cnt = `ZERO2;
            next_tally = `ZERO2;
            next_is_write = 1'b0;
            if (sysrst_sync) begin
                next_fault = '0;
            end
        end
        if (frozen) begin
            // Hold state and fault bits for probing
            next_state = state;
            next_fault = fault;
        end
    end

    // Operation state registers
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state <= ST_IDLE;
            retry_cnt <= `ZERO2;
            tally <= `ZERO2;
            is_write <= 1'b0;
            track_read_ff <= 1'b0;
            fault <= '0;
            op_disconnect_reset <= 1'b0;
            partition_number <= '0;
        end else begin
            state <= next_state;
            retry_cnt <= next_retry_cnt;
            tally <= next_tally;
            is_write <= next_is_write;
            track_read_ff <= next_track_read;
            fault <= next_fault;
            op_disconnect_reset <= next_disc_rst;
            partition_number <= next_partition;
        end
    end

    // Third attempt flag straight from the tally
    assign write_attempt_three = tally == `WRITE_LIMIT;

    // Tunnel erase: JK style set/clear at sector positions
    always_comb begin
        next_tunnel = tunnel_erase_ff;
        if (state != ST_WRITE && state != ST_VERIFY) begin
            next_tunnel = 1'b0;
        end else if (sector_pulse && cylinder_addr == erase_on_sector) begin
            next_tunnel = 1'b1;
        end else if (sector_pulse && cylinder_addr == erase_off_sector) begin
            next_tunnel = 1'b0;
        end
    end
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            tunnel_erase_ff <= 1'b0;
        end else begin
            tunnel_erase_ff <= next_tunnel;
        end
    end

    // Select lines: registered, forced low while system reset
    logic [`SEL_W-1:0] sel, next_sel;
    always_comb begin
        next_sel = sysrst_sync ? '0 : select_request;
    end
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            sel <= '0;
        end else begin
            sel <= next_sel;
        end
    end
    assign select_control_group = sel[`SEL_CONTROL];
    assign select_cylinder_group = sel[`SEL_CYLINDER];
    assign select_head_direction_group = sel[`SEL_HEAD_DIR];
    assign select_difference_group = sel[`SEL_DIFFERENCE];

    // Write gate only to the selected drive half
    assign write_a = (state == ST_WRITE) && !drive_b_selected;
    assign write_b = (state == ST_WRITE) && drive_b_selected;

    // Status character presented while in status state
    assign status_ready = state == ST_STATUS;
    logic [`STATUS_W-1:0] next_chan;
    always_comb begin
        next_chan = '0;
        if (next_state == ST_STATUS) begin
            next_chan = {{(`STATUS_W-4){1'b0}}, next_fault};
        end
    end
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            channel_data_lines <= '0;
        end else begin
            channel_data_lines <= next_chan;
        end
    end

    // Checks
    property p_sel_reset;
        @(posedge clk_sys) disable iff (!reset_n)
        sysrst_sync |=> sel == '0;
    endproperty
    a_sel_reset: assert property (p_sel_reset)
        else $error("select active during reset");
    property p_part_clear;
        @(posedge clk_sys) disable iff (!reset_n)
        transfer_terminate_pulse |=> partition_number == '0;
    endproperty
    a_part_clear: assert property (p_part_clear)
        else $error("partition not cleared");
    property p_track_read_ff;
        @(posedge clk_sys) disable iff (!reset_n)
        (state == ST_IDLE && start_write && !controller_clear)
            |=> track_read_ff;
    endproperty
    a_track_read_ff: assert property (p_track_read_ff)
        else $error("track read flag not set");
    property p_wrong;
        @(posedge clk_sys) disable iff (!reset_n)
        (state == ST_COMPARE && !id_match && retry_cnt == `RETRY_LIMIT
            && !controller_clear && !frozen)
            |=> fault.wrong_track && fault.error && fault.recal;
    endproperty
    a_wrong: assert property (p_wrong)
        else $error("wrong track not flagged");
    property p_no_early_wrong;
        @(posedge clk_sys) disable iff (!reset_n)
        $rose(fault.wrong_track) |-> $past(retry_cnt) == `RETRY_LIMIT;
    endproperty
    a_no_early_wrong: assert property (p_no_early_wrong)
        else $error("wrong track flagged early");
    property p_bad;
        @(posedge clk_sys) disable iff (!reset_n)
        $rose(fault.bad_sector) |-> $past(tally) == `WRITE_LIMIT;
    endproperty
    a_bad: assert property (p_bad)
        else $error("sector marked bad early");
    property p_pulse;
        @(posedge clk_sys) disable iff (!reset_n)
        preamble_detect_pulse |=> !preamble_detect_pulse;
    endproperty
    a_pulse: assert property (p_pulse)
        else $error("preamble pulse too long");
    property p_write_route;
        @(posedge clk_sys) disable iff (!reset_n)
        !(write_a && write_b);
    endproperty
    a_write_route: assert property (p_write_route)
        else $error("both drives written");
    property p_clear;
        @(posedge clk_sys) disable iff (!reset_n)
        sysrst_sync |=> state == ST_IDLE && tally == `ZERO2;
    endproperty
    a_clear: assert property (p_clear)
        else $error("reset did not clear");
    c_wrong: cover property (@(posedge clk_sys) $rose(fault.wrong_track));
    c_bad: cover property (@(posedge clk_sys) $rose(fault.bad_sector));
    c_disc: cover property (@(posedge clk_sys) op_disconnect_reset);
endmodule // disc_track_verify_write_retry

// ### rtl/pulse_gen.sv
// Rising edge to single pulse generator
`timescale 1ns/1ps
module pulse_gen (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic level,
    output logic pulse
);
    logic last;
    logic next_last;
    // Remember previous level
    always_comb begin
        next_last = level;
    end
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            last <= 1'b0;
        end else begin
            last <= next_last;
        end
    end
    // One cycle per rising edge
    assign pulse = level & ~last;
endmodule // pulse_gen

// ### verif/disc_track_verify_write_retry_bench.sv
// Self-checking bench for the track verify and write retry block
`timescale 1ns/1ps
`include "disc_ctl_defines.svh"
module disc_track_verify_write_retry_bench;
    import disc_ctl_pkg::*;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b1; // Pulled low just after time zero
    logic pfmr = 1'b0; // System reset pin
    logic [3:0] sel = 4'h0;
    logic st_rd = 1'b0, st_wr = 1'b0, seek = 1'b0, vp = 1'b1, tm = 1'b1;
    logic term = 1'b0, pload = 1'b0, hold = 1'b0, drv_b = 1'b0;
    logic taken = 1'b0;
    logic [7:0] pin = 8'hA5;
    logic [5:0] cyl = 6'h3F;
    logic [5:0] eon = 6'h3F, eoff = 6'h00; // Tunnel erase on/off points
    logic pp_last = 1'b0; // Preamble pulse one sample back
    logic on_cyl, pre, spulse, vok, vdone;
    logic [5:0] tid;
    logic s0, s1, s2, s3, wa, wb, tun, trd, w3, disc, ppulse, srdy;
    logic [7:0] chan, part;
    fault_t fault;
    int n_mismatch = 0, checked = 0, na = 0, nb = 0, nt = 0;
    // 25 MHz system clock
    always #20 clk_sys = ~clk_sys;
    disc_track_verify_write_retry dut_u (.clk_sys(clk_sys),
        .reset_n(reset_n), .power_fail_manual_reset(pfmr),
        .select_request(sel), .start_read(st_rd), .start_write(st_wr),
        .seek_needed(seek), .on_cylinder(on_cyl), .preamble_seen(pre),
        .track_id_in(tid), .cylinder_addr(cyl), .verify_ok(vok),
        .verify_done(vdone), .sector_pulse(spulse),
        .erase_on_sector(eon), .erase_off_sector(eoff),
        .transfer_terminate_pulse(term), .partition_in(pin),
        .partition_load(pload), .hold_on_fault_switch(hold),
        .drive_b_selected(drv_b), .status_taken(taken),
        .select_control_group(s0), .select_cylinder_group(s1),
        .select_head_direction_group(s2),
        .select_difference_group(s3), .write_a(wa), .write_b(wb),
        .tunnel_erase_ff(tun), .track_read_ff(trd),
        .write_attempt_three(w3), .op_disconnect_reset(disc),
        .preamble_detect_pulse(ppulse), .status_ready(srdy),
        .channel_data_lines(chan), .partition_number(part),
        .fault(fault));
    drive_model far_u (.clk_sys(clk_sys), .reset_n(reset_n),
        .write_a(wa), .write_b(wb), .cylinder_addr(cyl),
        .track_match(tm), .verify_pass(vp), .on_cylinder(on_cyl),
        .preamble_seen(pre), .sector_pulse(spulse),
        .track_id_in(tid), .verify_ok(vok), .verify_done(vdone));
    // Tally strobes at mid-cycle, clear of the launching edge
    always @(negedge clk_sys) begin
        na += (wa === 1'b1);
        nb += (wb === 1'b1);
        nt += (tun === 1'b1);
        if (ppulse === 1'b1 && pp_last === 1'b1)
            check(8'h01, 8'h00);
        pp_last = ppulse;
    end
    // Compare and report one value
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    // Step n cycles, landing just after the edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #2;
    endtask
    // Verdict and end of run
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Start an operation; the sampling edge lands inside the tick
    task automatic start_op(input logic wr);
        na = 0;
        nb = 0;
        nt = 0;
        st_wr = wr;
        st_rd = ~wr;
        tick(1);
        st_wr = 1'b0;
        st_rd = 1'b0;
    endtask
    // Bounded wait for status ready
    task automatic wait_status();
        int i;
        for (i = 0; i < 600 && srdy !== 1'b1; i++)
            tick(1);
        if (srdy !== 1'b1) begin
            check(1'b0, 1'b1);
            print_verdict();
        end
    endtask
    // Hand status back to the controller
    task automatic take_status();
        taken = 1'b1;
        tick(1);
        taken = 1'b0;
        tick(2);
    endtask
    initial begin
        int g;
        tick(0);
        reset_n = 1'b0;
        tick(20);
        reset_n = 1'b1;
        check({s3, s2, s1, s0, wa, wb, srdy, disc}, 8'h00);
        for (g = 0; g < 4; g++) begin
            sel = 4'h1 << g;
            tick(2);
            check({4'h0, s3, s2, s1, s0}, {4'h0, sel});
        end
        pfmr = 1'b1;
        tick(4);
        check({4'h0, s3, s2, s1, s0}, 8'h00);
        pfmr = 1'b0;
        sel = 4'h0;
        tick(4);
        $display("select groups done");
        pload = 1'b1;
        tick(1);
        pload = 1'b0;
        tick(1);
        check(part, 8'hA5);
        term = 1'b1;
        tick(1);
        term = 1'b0;
        tick(1);
        check(part, 8'h00);
        $display("partition done");
        seek = 1'b1;
        start_op(1'b1);
        check({trd, disc}, 2'h3);
        seek = 1'b0;
        tick(1);
        check(disc, 1'b0);
        wait_status();
        check({na[3:0], nb[3:0]}, 8'h10);
        check(chan, 8'h00);
        take_status();
        check(srdy, 1'b0);
        drv_b = 1'b1;
        vp = 1'b0;
        start_op(1'b1);
        wait_status();
        check({na[3:0], nb[3:0]}, 8'h03);
        check(w3, 1'b1);
        check({4'h0, fault}, 8'h06);
        check(chan, 8'h06);
        check(nt > 0, 1'b1);
        take_status();
        $display("write retry done");
        tm = 1'b0;
        start_op(1'b0);
        wait_status();
        check({4'h0, fault}, 8'h0D);
        check(na[3:0] + nb[3:0], 4'h0);
        take_status();
        tm = 1'b1;
        vp = 1'b1;
        eon = 6'h00;
        eoff = 6'h3F;
        start_op(1'b1);
        wait_status();
        check({3'h0, w3, fault}, 8'h00);
        check(nb[3:0], 4'h1);
        check(nt[7:0], 8'h00);
        take_status();
        $display("track compare done");
        hold = 1'b1;
        vp = 1'b0;
        tick(3);
        start_op(1'b1);
        wait_status();
        take_status();
        check(srdy, 1'b1);
        check({3'h0, w3, fault}, 8'h16);
        pfmr = 1'b1;
        tick(4);
        pfmr = 1'b0;
        tick(2);
        check({3'h0, srdy, fault}, 8'h00);
        $display("hold on fault done");
        print_verdict();
    end
endmodule // disc_track_verify_write_retry_bench

// ### verif/drive_model.sv
// Behavioural disc drive answering the controller's sector and write cycles
`timescale 1ns/1ps
`include "disc_ctl_defines.svh"
module drive_model (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic write_a,
    input wire logic write_b,
    input wire logic [`TRACK_ID_W-1:0] cylinder_addr,
    input wire logic track_match,
    input wire logic verify_pass,
    output logic on_cylinder,
    output logic preamble_seen,
    output logic sector_pulse,
    output logic [`TRACK_ID_W-1:0] track_id_in,
    output logic verify_ok,
    output logic verify_done
);
    logic [3:0] spin; // Sector rotation phase
    logic [1:0] vwait; // Read-after-write delay
    // A wrong track sits one step out, wrapping modulo 64
    assign track_id_in = track_match ? cylinder_addr
                                     : cylinder_addr + 6'h01;
    // Inverted outside the done pulse so a stale value never passes
    assign verify_ok = verify_done ? verify_pass : ~verify_pass;
    // Preamble every 12 cycles; held two cycles to survive the sync
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            spin <= 4'h0;
            vwait <= 2'h0;
            on_cylinder <= 1'b0;
            preamble_seen <= 1'b0;
            sector_pulse <= 1'b0;
            verify_done <= 1'b0;
        end else begin
            on_cylinder <= 1'b1;
            spin <= (spin == 4'hB) ? 4'h0 : spin + 4'h1;
            preamble_seen <= (spin < 4'h2);
            sector_pulse <= (spin == 4'h6);
            // Read-after-write answer two cycles after each write
            vwait <= (write_a | write_b) ? 2'h2
                   : (vwait != 2'h0) ? vwait - 2'h1 : 2'h0;
            verify_done <= (vwait == 2'h1);
        end
    end
endmodule // drive_model
